// >>> src/trx_irq.sv
// Excessive-zero change and oversize frame interrupt status and enable logic
// Overview of operation
// - Flag set when zero condition starts
// - Flag also set when zero condition clears
// - Zero flag clears on read, resets zero
// - Zero enable bit gates its request
// - Frame over 276 bytes sets long flag
// - Long flag reads once, clears on read
// - Long enable bit gates its request
`timescale 1ns/1ps
module trx_irq (
  input  wire logic        clock_in,          // 100 MHz clock
  input  wire logic        resetn_in,         // Asynchronous reset, active low
  input  wire logic [7:0]  addr_in,           // Register address
  input  wire logic [7:0]  wdata_in,          // Write data
  input  wire logic        wr_in,             // Write strobe
  input  wire logic        rd_in,             // Read strobe
  output logic      [7:0]  rdata_out,         // Read data, cycle after strobe
  input  wire logic        zero_run_in,       // Excessive-zero condition, pin level
  input  wire logic        frame_done_in,     // One-cycle pulse at end of frame
  input  wire logic [15:0] frame_len_in,      // Byte count of frame just ended
  output logic             irq_out            // Level interrupt request
);

  // All registered state of the block outside the synchroniser
  typedef struct packed {
    logic       zero_prev;                   // Previous synchronised condition
    logic       zero_run_change_flag;        // Sticky change flag
    logic       zero_run_change_irq_en;      // Change enable
    logic       oversize_frame_flag_ctl1;    // Sticky oversize flag
    logic       oversize_frame_irq_en_ctl1;  // Oversize enable
    logic [7:0] rdata;                       // Read data register
    logic       irq;                         // Registered request
  } trx_state_t;

  trx_state_t state;       // Current state
  trx_state_t next_state;  // Next state
  logic       zero_sync;   // Synchronised condition

  // Condition comes from the line domain; synchronise before use
  trx_sync u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (zero_run_in),
    .sync_out  (zero_sync)
  );

  // Builds an 8-bit register view with one flag in the low bit
  function automatic logic [7:0] flag_byte(input logic f);
    flag_byte = {7'h00, f};
  endfunction : flag_byte

  // Next-state logic: events, register access, interrupt
  always_comb begin
    logic zero_evt;  // Either edge of the condition
    logic long_evt;  // Oversize frame seen
    zero_evt   = 1'b0;
    long_evt   = 1'b0;
    next_state = state;
    zero_evt   = zero_sync ^ state.zero_prev;
    long_evt   = frame_done_in && (frame_len_in > trx_pkg::MAX_FRAME_BYTES);
    next_state.zero_prev = zero_sync;
    next_state.rdata     = trx_pkg::RST_DATA;
    // Reads return data and clear sticky flags
    if (rd_in) begin
      case (addr_in)
        trx_pkg::ADDR_ZERO_RUN_CHANGE_FLAG: begin
          next_state.rdata = flag_byte(state.zero_run_change_flag);
          next_state.zero_run_change_flag = 1'b0;
        end
        trx_pkg::ADDR_EXZ_ENABLE: begin
          next_state.rdata = flag_byte(state.zero_run_change_irq_en);
        end
        trx_pkg::ADDR_LF_STATUS: begin
          next_state.rdata = flag_byte(state.oversize_frame_flag_ctl1);
          next_state.oversize_frame_flag_ctl1 = 1'b0;
        end
        trx_pkg::ADDR_LF_ENABLE: begin
          next_state.rdata = flag_byte(state.oversize_frame_irq_en_ctl1);
        end
        trx_pkg::ADDR_INT_STATE: begin
          next_state.rdata = {6'h00, state.irq, zero_sync};
        end
        default: begin
          next_state.rdata = trx_pkg::RST_DATA;  // Unmapped reads as zero
        end
      endcase
    end
    // Writes to the enable registers
    if (wr_in) begin
      case (addr_in)
        trx_pkg::ADDR_EXZ_ENABLE: begin
          next_state.zero_run_change_irq_en = wdata_in[trx_pkg::FLAG_BIT];
        end
        trx_pkg::ADDR_LF_ENABLE: begin
          next_state.oversize_frame_irq_en_ctl1 = wdata_in[trx_pkg::FLAG_BIT];
        end
        default: begin
          next_state.irq = next_state.irq;  // Other writes ignored
        end
      endcase
    end
    // Event wins over a clear in the same cycle
    if (zero_evt) begin
      next_state.zero_run_change_flag = 1'b1;
    end
    if (long_evt) begin
      next_state.oversize_frame_flag_ctl1 = 1'b1;
    end
    // Request from enabled flags
    next_state.irq = (next_state.zero_run_change_flag & next_state.zero_run_change_irq_en)
      | (next_state.oversize_frame_flag_ctl1 & next_state.oversize_frame_irq_en_ctl1);
  end

  // State register
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.zero_prev                  <= 1'b0;
      state.zero_run_change_flag       <= trx_pkg::RST_FLAG;
      state.zero_run_change_irq_en     <= trx_pkg::RST_EN;
      state.oversize_frame_flag_ctl1   <= trx_pkg::RST_FLAG;
      state.oversize_frame_irq_en_ctl1 <= trx_pkg::RST_EN;
      state.rdata                      <= trx_pkg::RST_DATA;
      state.irq                        <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;  // Registered read data
  assign irq_out   = state.irq;    // Registered request

endmodule : trx_irq

// >>> src/trx_pkg.sv
// Package of register map, field positions and reset values for the interrupt block
package trx_pkg;

  // Register offsets (low byte of the printed addresses)
  localparam logic [7:0] ADDR_ZERO_RUN_CHANGE_FLAG = 8'h0e;  // excess_zero_change_status
  localparam logic [7:0] ADDR_EXZ_ENABLE = 8'h0f;  // excess_zero_change_enable
  localparam logic [7:0] ADDR_LF_STATUS  = 8'h10;  // long_frame_status_hdlc1
  localparam logic [7:0] ADDR_LF_ENABLE  = 8'h11;  // long_frame_enable_hdlc1
  localparam logic [7:0] ADDR_INT_STATE  = 8'h12;  // Live condition and request view

  // Field positions
  localparam int FLAG_BIT = 0;  // Status or enable bit in each flag and enable register
  localparam int IRQ_BIT  = 1;  // Request bit in the live view

  // Reset values
  localparam logic       RST_FLAG = 1'b0;  // Status flags after reset
  localparam logic       RST_EN   = 1'b0;  // Enable bits after reset
  localparam logic [7:0] RST_DATA = 8'h00; // Read data after reset

  // Frame length limit in bytes; longer frames raise the event
  localparam logic [15:0] MAX_FRAME_BYTES = 16'h0114;  // 276

endpackage : trx_pkg

// >>> src/trx_sync.sv
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module trx_sync (
  input  wire logic clock_in,   // System clock
  input  wire logic resetn_in,  // Asynchronous reset, active low
  input  wire logic async_in,   // Level from another domain
  output logic      sync_out    // Level safe to use
);
  logic stage1;  // First stage, read only by the second

  // Two-stage capture
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : trx_sync

// >>> tb/trx_irq_assertions.sv
// Checker of read data and interrupt request timing for the interrupt block
`timescale 1ns/1ps
module trx_irq_chk (
  input wire logic        clock_in,       // Clock
  input wire logic        resetn_in,      // Reset, active low
  input wire logic [7:0]  addr_in,        // Register address
  input wire logic [7:0]  wdata_in,       // Write data
  input wire logic        wr_in,          // Write strobe
  input wire logic        rd_in,          // Read strobe
  input wire logic [7:0]  rdata_out,      // Read data
  input wire logic        zero_run_in,    // Zero-run condition
  input wire logic        frame_done_in,  // End of frame
  input wire logic [15:0] frame_len_in,   // Frame byte count
  input wire logic        irq_out         // Interrupt request
);
  logic ze;   // Mirror of zero-run enable
  logic le;   // Mirror of long-frame enable
  logic big;  // Oversize frame ends now
  assign big = frame_done_in && (frame_len_in > trx_pkg::MAX_FRAME_BYTES);
  // Mirror both enable bits from writes
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ze <= 1'b0;
      le <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == trx_pkg::ADDR_EXZ_ENABLE) ze <= wdata_in[trx_pkg::FLAG_BIT];
      if (addr_in == trx_pkg::ADDR_LF_ENABLE)  le <= wdata_in[trx_pkg::FLAG_BIT];
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero");
  a_zero_en_read: assert property (rd_in && addr_in == 8'h0f |=> rdata_out == {7'h00, $past(ze)})
    else $error("zero enable readback wrong");
  a_long_en_read: assert property (rd_in && addr_in == 8'h11 |=> rdata_out == {7'h00, $past(le)})
    else $error("long enable readback wrong");
  a_long_irq_set: assert property (big && le && !wr_in |=> irq_out)
    else $error("no request after long frame");
  a_long_flag_read: assert property (big ##1 (rd_in && addr_in == 8'h10) |=> rdata_out == 8'h01)
    else $error("long flag not read");
  a_read_clears: assert property ((rd_in && addr_in == 8'h10 && !big) ##1 (rd_in && addr_in == 8'h10 && !big) |=> rdata_out == 8'h00)
    else $error("long flag not cleared");
  a_no_enable_quiet: assert property (!ze && !le && !wr_in |=> !irq_out)
    else $error("request while disabled");
  a_zero_edge_irq: assert property ($changed(zero_run_in) && ze && !wr_in |-> ##[1:5] irq_out)
    else $error("no request after zero change");
  c_long: cover property (big && le);
  c_zero: cover property ($changed(zero_run_in) && ze);
  c_drop: cover property (irq_out ##1 !irq_out);
endmodule : trx_irq_chk
bind trx_irq trx_irq_chk u_chk (.*);

// >>> tb/trx_irq_tb_top.sv
// Self-checking testbench for the interrupt status and enable block
`timescale 1ns/1ps
module trx_irq_tb_top;
  logic        clock_in, resetn_in, wr_in, rd_in, zero_run_in, frame_done_in, irq_out, rd_seen;
  logic [7:0]  addr_in, wdata_in, rdata_out;
  logic [15:0] frame_len_in, n;
  logic [31:0] seed = 32'h578f1456;  // Random state
  logic [7:0]  q[$];                 // Expected read data, oldest first
  int          err_count = 0;
  int          n_tests = 0;
  trx_irq dut (.*);
  // Free running clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // One cycle on all strobes; a read notes its expected data
  task automatic bus(input logic w, input logic r, input logic f, input logic [7:0] a, d);
    @(posedge clock_in);
    wr_in <= w;
    rd_in <= r;
    frame_done_in <= f;
    addr_in <= a;
    wdata_in <= d;
    if (r) q.push_back(d);
  endtask : bus
  task automatic idle(input int k);
    repeat (k) bus(1'b0, 1'b0, 1'b0, 8'h00, 8'(xs()));
  endtask : idle
  task automatic chk(input logic e);
    @(negedge clock_in);
    cmp({7'h00, irq_out}, {7'h00, e});
  endtask : chk
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Compare read data in the cycle after each read
  always @(posedge clock_in) rd_seen <= rd_in;
  always @(negedge clock_in) if (rd_seen) cmp(rdata_out, q.pop_front());
  initial begin
    #50000;
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {resetn_in, wr_in, rd_in, zero_run_in, frame_done_in} = 5'h00;
    {addr_in, wdata_in, frame_len_in} = 32'h00000000;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    for (int a = 14; a < 19; a++) bus(1'b0, 1'b1, 1'b0, 8'(a), 8'h00);
    bus(1'b0, 1'b1, 1'b0, 8'h20, 8'h00);
    bus(1'b1, 1'b0, 1'b0, 8'h0f, 8'(xs()) | 8'h01);
    bus(1'b1, 1'b0, 1'b0, 8'h11, 8'(xs()) | 8'h01);
    bus(1'b0, 1'b1, 1'b0, 8'h0f, 8'h01);
    bus(1'b0, 1'b1, 1'b0, 8'h11, 8'h01);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 16'h0114 : (i == 1) ? 16'h0115 : 16'(xs());
      bus(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
      frame_len_in <= n;
      idle(1);
      chk(n > 16'h0114);
      bus(1'b0, 1'b1, 1'b0, 8'h10, {7'h00, n > 16'h0114});
      bus(1'b0, 1'b1, 1'b0, 8'h10, 8'h00);
      idle(2);
      chk(1'b0);
    end
    for (int i = 1; i >= 0; i--) begin
      @(posedge clock_in);
      zero_run_in <= i[0];
      idle(6);
      chk(1'b1);
      bus(1'b0, 1'b1, 1'b0, 8'h12, {6'h00, 1'b1, i[0]});
      bus(1'b0, 1'b1, 1'b0, 8'h0e, 8'h01);
      bus(1'b0, 1'b1, 1'b0, 8'h0e, 8'h00);
      idle(2);
      chk(1'b0);
    end
    bus(1'b1, 1'b0, 1'b0, 8'h0f, 8'(xs()) & 8'hfe);
    bus(1'b1, 1'b0, 1'b0, 8'h11, 8'(xs()) & 8'hfe);
    bus(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    frame_len_in <= 16'h012c;
    zero_run_in <= 1'b1;
    idle(6);
    chk(1'b0);
    bus(1'b0, 1'b1, 1'b0, 8'h0e, 8'h01);
    bus(1'b0, 1'b1, 1'b0, 8'h10, 8'h01);
    bus(1'b0, 1'b1, 1'b1, 8'h10, 8'h00);
    bus(1'b0, 1'b1, 1'b0, 8'h10, 8'h01);
    idle(2);
    end_of_test();
  end
endmodule : trx_irq_tb_top
